// ==== ap1_host_model.sv ====
// Host alert input model watching alert pin one.
// Assumes an open-drain pin with a pull-up; alert reads low.
`timescale 1ns/10ps
module ap1_host_model (
    input  wire logic PIN1_O,
    input  wire logic PIN1_OE,
    input  wire logic DRV_EN,
    input  wire logic DRV_VAL,
    output logic      PIN_LVL,
    output logic      ALERT_SEEN
);
    // Pull-up wins unless the device pulls low or host drives rate
    assign PIN_LVL = (PIN1_OE && !PIN1_O) ? 1'b0
                   : (DRV_EN ? DRV_VAL : 1'b1);
    // Host reads a low pin as an alert
    assign ALERT_SEEN = !PIN_LVL;
endmodule : ap1_host_model

// ==== ap1_pkg.sv ====
// Types shared by the alert pin one routing block.
// Assumes ap1_regs.svh is on the include path.
`include "ap1_regs.svh"

package ap1_pkg;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [23:0] wdata;
    } ap1_reg_req_t;

    // Tripped conditions, index 0 is channel one
    typedef struct packed {
        logic [3:0] oc;
        logic [3:0] uc;
        logic [3:0] ov;
        logic [3:0] uv;
        logic [3:0] op;
        logic       acc_full;
        logic       cnt_full;
    } ap1_trip_t;

    // Conversion pulse states
    typedef enum logic [0:0] {
        AP1_IDLE  = 1'b0,
        AP1_PULSE = 1'b1
    } ap1_pstate_t;

    // Whole state of the block
    typedef struct packed {
        logic [23:0] mask;
        ap1_pstate_t ps;
        logic [7:0]  cnt;
        logic        sync1;
        logic        sync2;
        logic        pin_oe;
        logic        slow_req;
        logic [23:0] rdata;
    } ap1_state_t;

endpackage : ap1_pkg

// ==== ap1_regs.svh ====
// Register offsets, field positions and timing counts of the
// alert pin one routing mask. Included by the package and the design.
`ifndef AP1_ROUTE_REGS_SVH
`define AP1_ROUTE_REGS_SVH

// Mask register offset on the register port
`define AP1_MASK_ADDR  8'h27
// Mask reset value and implemented bits
`define AP1_MASK_RST   24'h000000
`define AP1_MASK_IMPL  24'hFFFFFE
// Field positions; channel one sits at the top bit of each group
`define AP1_OC_MSB     23
`define AP1_UC_MSB     19
`define AP1_OV_MSB     15
`define AP1_UV_MSB     11
`define AP1_OP_MSB     7
`define AP1_ACC_BIT    3
`define AP1_CNT_BIT    2
`define AP1_CC_BIT     1
`define AP1_RSV_BIT    0
// Timing
`define AP1_CLK_NS     20
`define AP1_PULSE_NS   5000
`define AP1_PULSE_CYC  ((`AP1_PULSE_NS + `AP1_CLK_NS - 1) / `AP1_CLK_NS)

`endif

// ==== ap1_route.sv ====
// Alert pin one routing mask: masks tripped conditions onto the pin
// and adds a timed pulse at each conversion end.
// Assumes trip flags, conversion strobe and pin mode come from logic on
// CLK; only the pin input is asynchronous.
//
// Contract
// - OV enables channels two-four gate pin
// - UV enables channels one-four gate pin
// - OP enables channels one-four gate pin
// - Accumulator full enable routes alert
// - Sample count full enable routes alert
// - Conversion end gives 5 us pulse
// - Pin drives only in alert mode
// - Rate input ignored in alert mode
// - Bit zero reads zero, ignores writes
// - Channel one OV enable gates pin
// - Upper bits enable OC and UC
`timescale 1ns/10ps
`include "ap1_regs.svh"

module ap1_route
    import ap1_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire ap1_reg_req_t REG,
    output logic [23:0]       REG_RDATA,
    input  wire ap1_trip_t    TRIP,
    input  wire logic         CONV_DONE,
    input  wire logic         PIN_ALERT_MODE,
    input  wire logic         PIN1_I,
    output logic              PIN1_O,
    output logic              PIN1_OE,
    output logic              SLOW_REQ
);

    localparam logic [7:0] PULSE_LAST = 8'(`AP1_PULSE_CYC - 1);

    ap1_state_t st_reg;
    ap1_state_t st_next;
    logic [3:0] chan_hit;
    logic       any_hit;
    logic       mask_wr;

    // Register port decode
    function automatic logic is_mask(input logic [7:0] addr);
        is_mask = (addr == `AP1_MASK_ADDR);
    endfunction : is_mask

    // Per-channel masked conditions
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_chan
            assign chan_hit[i] =
                (TRIP.oc[i] & st_reg.mask[`AP1_OC_MSB - i]) |
                (TRIP.uc[i] & st_reg.mask[`AP1_UC_MSB - i]) |
                (TRIP.ov[i] & st_reg.mask[`AP1_OV_MSB - i]) |
                (TRIP.uv[i] & st_reg.mask[`AP1_UV_MSB - i]) |
                (TRIP.op[i] & st_reg.mask[`AP1_OP_MSB - i]);
        end
    endgenerate

    // Global OR of everything routed
    assign any_hit = (|chan_hit)
        | (TRIP.acc_full & st_reg.mask[`AP1_ACC_BIT])
        | (TRIP.cnt_full & st_reg.mask[`AP1_CNT_BIT]);
    assign mask_wr = REG.wr & is_mask(REG.addr);

    // Next state
    always_comb begin
        st_next = st_reg;
        // Mask write, bit zero never stored
        if (mask_wr) begin
            st_next.mask = REG.wdata & `AP1_MASK_IMPL;
        end
        // Conversion pulse timer, restarts on each conversion end
        case (st_reg.ps)
            AP1_IDLE: begin
                st_next.cnt = 8'h00;
            end
            AP1_PULSE: begin
                if (st_reg.cnt == PULSE_LAST) begin
                    st_next.ps = AP1_IDLE;
                    st_next.cnt = 8'h00;
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            default: begin
                st_next.ps = AP1_IDLE;
                st_next.cnt = 8'h00;
            end
        endcase
        if (CONV_DONE && st_reg.mask[`AP1_CC_BIT]) begin
            st_next.ps = AP1_PULSE;
            st_next.cnt = 8'h00;
        end
        // Disabling the pulse cuts a running one short
        if (!st_reg.mask[`AP1_CC_BIT]) begin
            st_next.ps = AP1_IDLE;
            st_next.cnt = 8'h00;
        end
        // Pin input synchroniser
        st_next.sync1 = PIN1_I;
        st_next.sync2 = st_reg.sync1;
        // Pin drive only while configured as alert output
        st_next.pin_oe = PIN_ALERT_MODE
            & (any_hit | (st_next.ps == AP1_PULSE));
        // Rate reduction request only outside alert mode
        st_next.slow_req = !PIN_ALERT_MODE & st_reg.sync2;
        // Read data, unmapped offsets read zero
        st_next.rdata = is_mask(REG.addr) ? st_reg.mask : 24'h000000;
    end

    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg <= '0;
            st_reg.mask <= `AP1_MASK_RST;
            st_reg.ps <= AP1_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs; pin is open drain, driven low while asserted
    assign REG_RDATA = st_reg.rdata;
    assign PIN1_O    = 1'b0;
    assign PIN1_OE   = st_reg.pin_oe;
    assign SLOW_REQ  = st_reg.slow_req;

    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Conversion end seen with pulse enabled
    sequence s_conv_start;
        CONV_DONE && st_reg.mask[`AP1_CC_BIT];
    endsequence

    // Last counted cycle of a pulse with no restart
    sequence s_pulse_last;
        st_reg.ps == AP1_PULSE && st_reg.cnt == PULSE_LAST && !CONV_DONE;
    endsequence

    AST_OV_CH2: assert property (
        PIN_ALERT_MODE && TRIP.ov[1] && st_reg.mask[14] && !mask_wr
        |=> PIN1_OE)
        else $error("ch2 overvoltage not routed");

    AST_UV_CH1: assert property (
        PIN_ALERT_MODE && TRIP.uv[0] && st_reg.mask[11] |=> PIN1_OE)
        else $error("ch1 undervoltage not routed");

    AST_OP_CH4: assert property (
        PIN_ALERT_MODE && TRIP.op[3] && st_reg.mask[4] |=> PIN1_OE)
        else $error("ch4 overpower not routed");

    AST_ACC: assert property (
        PIN_ALERT_MODE && TRIP.acc_full && st_reg.mask[3] |=> PIN1_OE)
        else $error("accumulator full not routed");

    AST_CNT: assert property (
        PIN_ALERT_MODE && TRIP.cnt_full && st_reg.mask[2] |=> PIN1_OE)
        else $error("sample count full not routed");

    AST_PULSE_START: assert property (
        s_conv_start and PIN_ALERT_MODE
        |=> st_reg.ps == AP1_PULSE && st_reg.cnt == 8'h00 && PIN1_OE)
        else $error("conversion pulse did not start");

    AST_PULSE_END: assert property (
        s_pulse_last |=> st_reg.ps == AP1_IDLE)
        else $error("conversion pulse length wrong");

    AST_PULSE_HOLD: assert property (
        st_reg.ps == AP1_PULSE && st_reg.mask[1]
        && st_reg.cnt < PULSE_LAST |=> st_reg.ps == AP1_PULSE)
        else $error("conversion pulse ended early");

    AST_PULSE_OFF: assert property (
        !st_reg.mask[1] |=> st_reg.ps == AP1_IDLE)
        else $error("pulse running while disabled");

    AST_MODE_GATE: assert property (
        !PIN_ALERT_MODE |=> !PIN1_OE)
        else $error("pin driven outside alert mode");

    AST_RATE_OFF: assert property (
        PIN_ALERT_MODE |=> !SLOW_REQ)
        else $error("rate input honoured in alert mode");

    AST_BIT0: assert property (
        mask_wr |=> !st_reg.mask[0] ##1 !REG_RDATA[0])
        else $error("reserved bit stored");

    AST_OV_CH1: assert property (
        PIN_ALERT_MODE && TRIP.ov[0] && st_reg.mask[15] |=> PIN1_OE)
        else $error("ch1 overvoltage not routed");

    AST_OC_UC: assert property (
        PIN_ALERT_MODE && ((TRIP.oc[0] && st_reg.mask[23])
        || (TRIP.uc[3] && st_reg.mask[16])) |=> PIN1_OE)
        else $error("current alert not routed");

    AST_QUIET: assert property (
        !any_hit && st_next.ps == AP1_IDLE |=> !PIN1_OE)
        else $error("pin driven with nothing routed");

    AST_READBACK: assert property (
        mask_wr ##1 !mask_wr && is_mask(REG.addr)
        |=> REG_RDATA == ($past(REG.wdata, 2) & `AP1_MASK_IMPL))
        else $error("mask readback mismatch");

    // Outside alert mode the synchronised pin level reaches the request
    AST_RATE_PASS: assert property (
        !PIN_ALERT_MODE && st_reg.sync2 |=> SLOW_REQ)
        else $error("rate input lost outside alert mode");

    AST_UV_CH3: assert property (
        PIN_ALERT_MODE && TRIP.uv[2] && st_reg.mask[9] |=> PIN1_OE)
        else $error("ch3 undervoltage not routed");

endmodule : ap1_route

// ==== tb.sv ====
// Self-checking bench for the alert pin one routing block.
// Assumes ap1_pkg, ap1_route and the host model are compiled first.
`timescale 1ns/10ps
`include "ap1_regs.svh"
module tb
    import ap1_pkg::*;
;
    logic         clk;
    logic         rst;
    ap1_reg_req_t req;
    logic [23:0]  rdata;
    ap1_trip_t    trip;
    logic         conv, mode, p_o, p_oe, slow, lvl, seen, drv_en, drv_v;
    int           bad_count, check_count;

    // Clock and instances
    always #10 clk = ~clk;
    ap1_route i_ap1_route (.CLK(clk), .RST(rst), .REG(req),
        .REG_RDATA(rdata), .TRIP(trip), .CONV_DONE(conv),
        .PIN_ALERT_MODE(mode), .PIN1_I(lvl), .PIN1_O(p_o),
        .PIN1_OE(p_oe), .SLOW_REQ(slow));
    ap1_host_model i_ap1_host_model (.PIN1_O(p_o), .PIN1_OE(p_oe),
        .DRV_EN(drv_en), .DRV_VAL(drv_v), .PIN_LVL(lvl),
        .ALERT_SEEN(seen));

    // Step past edges, then settle
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Compare and count
    task check(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Register port write and read
    task wr(input logic [7:0] a, input logic [23:0] d);
        req = '{1'b1, a, d};
        cyc(1);
        req.wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [23:0] d);
        req.addr = a;
        cyc(1);
        d = rdata;
    endtask : rd

    // Reset values, reserved bit zero, foreign offset
    task t_regs;
        logic [23:0] d;
        rd(`AP1_MASK_ADDR, d);
        check(d, `AP1_MASK_RST);
        check({p_oe, slow}, 2'b00);
        wr(`AP1_MASK_ADDR, 24'hFFFFFF);
        rd(`AP1_MASK_ADDR, d);
        check(d, 24'hFFFFFE);
        wr(8'h28, 24'h000000);
        rd(8'h28, d);
        check(d, 24'h000000);
        rd(`AP1_MASK_ADDR, d);
        check(d, 24'hFFFFFE);
        $display("t_regs done");
    endtask : t_regs

    // Each enable passes its own trip and blocks all others
    task t_route;
        int tb_i;
        mode = 1'b1;
        for (int k = 0; k < 22; k++) begin
            tb_i = (k < 20) ? 18 - 4 * (k / 4) + k % 4 : 21 - k;
            wr(`AP1_MASK_ADDR, 24'h1 << (23 - k));
            trip = ~(22'h1 << tb_i); // Every trip but its own is set
            cyc(1);
            check(p_oe, 1'b0);
            trip = 22'h1 << tb_i;
            cyc(1);
            check(seen, 1'b1);
        end
        $display("t_route done");
    endtask : t_route

    // Rate input role against alert role
    task t_mode;
        wr(`AP1_MASK_ADDR, 24'hFFFFFE);
        trip = '1;
        mode = 1'b0;
        drv_en = 1'b1;
        drv_v = 1'b0;
        cyc(4);
        check({p_oe, slow}, 2'b00);
        drv_v = 1'b1;
        cyc(3);
        check({p_oe, slow}, 2'b01);
        mode = 1'b1;
        drv_en = 1'b0;
        cyc(1);
        check({p_oe, slow}, 2'b10);
        trip = '0;
        $display("t_mode done");
    endtask : t_mode

    // Conversion strobes at i=0 and i=r; count low pin cycles
    task conv_run(input int r, output int n);
        n = 0;
        for (int i = 0; i < 400; i++) begin
            conv = (i == 0 || i == r);
            cyc(1);
            if (seen === 1'b1) n++;
        end
    endtask : conv_run

    // Conversion pulse length, restart, mode and enable gating
    task t_pulse;
        int n;
        wr(`AP1_MASK_ADDR, 24'h000002);
        conv_run(1000, n);
        check(24'(n), 24'(`AP1_PULSE_CYC));
        conv_run(100, n);
        check(24'(n), 24'(`AP1_PULSE_CYC + 100));
        mode = 1'b0;
        conv_run(1000, n);
        check(24'(n), 24'h000000);
        mode = 1'b1;
        wr(`AP1_MASK_ADDR, 24'h000000);
        conv_run(1000, n);
        check(24'(n), 24'h000000);
        $display("t_pulse done");
    endtask : t_pulse

    // Verdict and end of run
    task test_done;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {clk, rst, conv, mode, drv_en, drv_v} = 6'b010001;
        req = '0;
        trip = '0;
        bad_count = 0;
        check_count = 0;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        t_regs;
        t_route;
        t_mode;
        t_pulse;
        test_done;
    end

    // Watchdog against a hang
    initial begin
        #80000;
        bad_count++;
        test_done;
    end
endmodule : tb
